//--- clkbuf_regs_pkg.sv
package clkbuf_regs_pkg;

  // register indices as seen by the management bus
  localparam logic [7:0] reserved_byte_four_idx = 8'h04;
  localparam logic [7:0] maker_and_revision_code_idx = 8'h05;
  localparam logic [7:0] part_code_idx = 8'h06;
  localparam logic [7:0] read_length_count_idx = 8'h07;
  localparam logic [7:0] reserved_byte_eight_idx = 8'h08;

  // read length field layout and value after reset
  localparam int read_len_width = 5;
  localparam logic [4:0] read_len_reset = 5'h08;
  localparam logic [7:0] reserved_reset = 8'h00;

  // maker and revision byte layout
  localparam int rev_code_lsb = 4;
  localparam int maker_code_lsb = 0;

  // bit counter limit and kinds of write byte
  localparam logic [3:0] bits_per_byte = 4'h8;
  localparam logic [1:0] rx_addr_byte = 2'h0;
  localparam logic [1:0] rx_index_byte = 2'h1;
  localparam logic [1:0] rx_count_byte = 2'h2;
  localparam logic [1:0] rx_data_byte = 2'h3;

  // one sampled pair of bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  // slave engine states
  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_rx_ack,
    st_tx,
    st_tx_ack
  } slave_state_t;

endpackage

//--- smbus_id_bytecount_regs.sv
`timescale 1ns/100ps
module smbus_id_bytecount_regs #(
  parameter logic [6:0] dev_addr = 7'h69,   // slave address, arbitrary default
  parameter logic [3:0] rev_code = 4'h3,    // arbitrary value
  parameter logic [3:0] maker_code = 4'h5,  // arbitrary value
  parameter logic [7:0] part_code = 8'h5a   // arbitrary value
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_ff,
  output logic sda_oe_n_ff,
  output logic [4:0] read_len_ff
);

  // three-stage samplers for the bus lines
  clkbuf_regs_pkg::bus_lines_t sync1_ff;
  clkbuf_regs_pkg::bus_lines_t sync2_ff;
  clkbuf_regs_pkg::bus_lines_t sync3_ff;
  // filtered levels and their previous values
  clkbuf_regs_pkg::bus_lines_t line_ff;
  clkbuf_regs_pkg::bus_lines_t prev_ff;
  // engine state
  clkbuf_regs_pkg::slave_state_t state_ff;
  logic [3:0] bit_cnt_ff;       // bits moved in the current byte
  logic [7:0] shift_ff;         // byte being received or sent
  logic [1:0] rx_kind_ff;       // which byte of a write this is
  logic [7:0] ptr_ff;           // current register index
  logic reading_ff;             // address phase asked for a read
  logic host_ack_ff;            // host acked the last byte sent

  // bus events seen on the filtered lines
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  // bytes ready to go out: the length register and the one at the index
  logic [7:0] len_byte;
  logic [7:0] ptr_byte;

  // read view of the register bank
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [4:0] len);
    logic [7:0] val;
    val = clkbuf_regs_pkg::reserved_reset;
    case (idx)
      clkbuf_regs_pkg::maker_and_revision_code_idx: begin
        val[clkbuf_regs_pkg::rev_code_lsb +: 4] = rev_code;
        val[clkbuf_regs_pkg::maker_code_lsb +: 4] = maker_code;
      end
      clkbuf_regs_pkg::part_code_idx: begin
        val = part_code;
      end
      clkbuf_regs_pkg::read_length_count_idx: begin
        val = {3'h0, len};
      end
      default: begin
        val = clkbuf_regs_pkg::reserved_reset;
      end
    endcase
    return val;
  endfunction

  // sample the pins through three flops
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_ff <= '{scl: 1'b1, sda: 1'b1};
      sync2_ff <= '{scl: 1'b1, sda: 1'b1};
      sync3_ff <= '{scl: 1'b1, sda: 1'b1};
    end else if (clk_en) begin
      sync1_ff <= '{scl: scl_in, sda: sda_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // accept a line change only once stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      line_ff <= '{scl: 1'b1, sda: 1'b1};
      prev_ff <= '{scl: 1'b1, sda: 1'b1};
    end else if (clk_en) begin
      prev_ff <= line_ff;
      if (sync2_ff.scl == sync3_ff.scl) begin
        line_ff.scl <= sync3_ff.scl;
      end
      if (sync2_ff.sda == sync3_ff.sda) begin
        line_ff.sda <= sync3_ff.sda;
      end
    end
  end

  // edges and bus conditions
  always_comb begin
    scl_rise = line_ff.scl && !prev_ff.scl;
    scl_fall = !line_ff.scl && prev_ff.scl;
    start_seen = line_ff.scl && prev_ff.scl && !line_ff.sda && prev_ff.sda;
    stop_seen = line_ff.scl && prev_ff.scl && line_ff.sda && !prev_ff.sda;
    byte_done = (bit_cnt_ff == clkbuf_regs_pkg::bits_per_byte);
    // read views computed once so the engine can slice them
    len_byte = reg_read(clkbuf_regs_pkg::read_length_count_idx, read_len_ff);
    ptr_byte = reg_read(ptr_ff, read_len_ff);
  end

  // slave engine: address, index, count, data and acks
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= clkbuf_regs_pkg::st_idle;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rx_kind_ff <= clkbuf_regs_pkg::rx_addr_byte;
      ptr_ff <= 8'h00;
      reading_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (clk_en) begin
      if (start_seen) begin
        // start or repeated start: index from the write phase is kept
        state_ff <= clkbuf_regs_pkg::st_rx;
        bit_cnt_ff <= 4'h0;
        rx_kind_ff <= clkbuf_regs_pkg::rx_addr_byte;
        sda_oe_n_ff <= 1'b1;
      end else if (stop_seen) begin
        // stop ends everything and frees the line
        state_ff <= clkbuf_regs_pkg::st_idle;
        sda_oe_n_ff <= 1'b1;
      end else begin
        case (state_ff)
          clkbuf_regs_pkg::st_rx: begin
            if (scl_rise && !byte_done) begin
              // shift in one bit, msb first
              shift_ff <= {shift_ff[6:0], line_ff.sda};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && byte_done) begin
              state_ff <= clkbuf_regs_pkg::st_rx_ack;
              sda_oe_n_ff <= 1'b0;
              if (rx_kind_ff == clkbuf_regs_pkg::rx_addr_byte) begin
                // address byte: answer only our own address
                if (shift_ff[7:1] == dev_addr) begin
                  reading_ff <= shift_ff[0];
                end else begin
                  state_ff <= clkbuf_regs_pkg::st_idle;
                  sda_oe_n_ff <= 1'b1;
                end
              end else if (rx_kind_ff == clkbuf_regs_pkg::rx_index_byte) begin
                ptr_ff <= shift_ff;
              end else if (rx_kind_ff == clkbuf_regs_pkg::rx_data_byte) begin
                ptr_ff <= ptr_ff + 8'h01;
              end
              if (rx_kind_ff != clkbuf_regs_pkg::rx_data_byte) begin
                rx_kind_ff <= rx_kind_ff + 2'h1;
              end
            end
          end
          clkbuf_regs_pkg::st_rx_ack: begin
            if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              if (reading_ff) begin
                // read: the length byte goes out first
                state_ff <= clkbuf_regs_pkg::st_tx;
                shift_ff <= {len_byte[6:0], 1'b0};
                sda_oe_n_ff <= len_byte[7];
                bit_cnt_ff <= 4'h1;
              end else begin
                state_ff <= clkbuf_regs_pkg::st_rx;
                sda_oe_n_ff <= 1'b1;
              end
            end
          end
          clkbuf_regs_pkg::st_tx: begin
            if (scl_fall) begin
              if (byte_done) begin
                // release for the host's ack bit
                state_ff <= clkbuf_regs_pkg::st_tx_ack;
                sda_oe_n_ff <= 1'b1;
              end else begin
                // open drain: a one is sent by releasing the line
                sda_oe_n_ff <= shift_ff[7];
                shift_ff <= {shift_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          clkbuf_regs_pkg::st_tx_ack: begin
            if (scl_rise) begin
              host_ack_ff <= !line_ff.sda;
            end else if (scl_fall) begin
              if (host_ack_ff) begin
                // next register byte from the current index
                state_ff <= clkbuf_regs_pkg::st_tx;
                shift_ff <= {ptr_byte[6:0], 1'b0};
                sda_oe_n_ff <= ptr_byte[7];
                bit_cnt_ff <= 4'h1;
                ptr_ff <= ptr_ff + 8'h01;
              end else begin
                // not acknowledged: wait for the stop
                state_ff <= clkbuf_regs_pkg::st_idle;
              end
            end
          end
          default: begin
            sda_oe_n_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // read length register: only the low five bits store
  always_ff @(posedge clock) begin
    if (reset) begin
      read_len_ff <= clkbuf_regs_pkg::read_len_reset;
    end else if (clk_en) begin
      if (!start_seen && !stop_seen && state_ff == clkbuf_regs_pkg::st_rx && scl_fall
          && byte_done && rx_kind_ff == clkbuf_regs_pkg::rx_data_byte
          && ptr_ff == clkbuf_regs_pkg::read_length_count_idx) begin
        read_len_ff <= shift_ff[clkbuf_regs_pkg::read_len_width-1:0];
      end
    end
  end

  // the data line output value is always low; the enable does the work
  always_ff @(posedge clock) begin
    if (reset) begin
      sda_out_ff <= 1'b0;
    end else if (clk_en) begin
      sda_out_ff <= 1'b0;
    end
  end

endmodule

//--- smbus_regs_chk.sv
`timescale 1ns/100ps
// watches the register bank pins
module smbus_regs_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_ff,
  input wire logic sda_oe_n_ff,
  input wire logic [4:0] read_len_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_len_reset_val: assert property (disable iff (1'b0)
    reset |=> read_len_ff == 5'h08 && sda_oe_n_ff)
    else $error("length or drive wrong after reset");
  a_len_frozen: assert property (!clk_en |=> $stable(read_len_ff))
    else $error("length moved while frozen");
  a_drive_frozen: assert property (!clk_en |=> $stable(sda_oe_n_ff))
    else $error("data drive moved while frozen");
  a_drive_scl_low: assert property ($changed(sda_oe_n_ff) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_out_open_drain: assert property (sda_out_ff == 1'b0)
    else $error("data output value not low");
  a_stop_release: assert property ($rose(sda_in) && scl_in |=> sda_oe_n_ff [*8])
    else $error("data line driven after stop");
  // main scenarios reached
  cover property (!sda_oe_n_ff ##1 sda_oe_n_ff);
  cover property (!clk_en);
  cover property ($changed(read_len_ff));
endmodule

bind smbus_id_bytecount_regs smbus_regs_chk chk (.clock(clock), .reset(reset), .clk_en(clk_en),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff),
  .read_len_ff(read_len_ff));

//--- smbus_host_model.sv
`timescale 1ns/100ps
// management bus host: drives the clock line, pulls the data line open drain
module smbus_host_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  logic nak_seen; // set when the device left a host byte unacknowledged
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nak_seen = 1'b0;
  end
  // wait n clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit: data set while clock low, sampled mid-high
  task automatic bit_cyc(input logic b, output logic r);
    scl <= 1'b0;
    hold(6);
    sda_drv <= b;
    hold(8);
    scl <= 1'b1;
    hold(8);
    r = sda_line;
    hold(6);
  endtask
  // start when first is high, stop when low
  task automatic edge_cond(input logic first);
    scl <= 1'b0;
    hold(6);
    sda_drv <= first;
    hold(8);
    scl <= 1'b1;
    hold(10);
    sda_drv <= !first;
    hold(10);
  endtask
  // send a byte msb first, note a missing acknowledge
  task automatic put_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], r);
    bit_cyc(1'b1, r);
    if (r) nak_seen = 1'b1;
  endtask
  // take a byte, acknowledge all but the last
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(last, r);
  endtask
  // write bytes from a start index
  task automatic write_regs(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d [$]);
    edge_cond(1'b1);
    put_byte({a, 1'b0});
    put_byte(idx);
    put_byte(8'(d.size()));
    foreach (d[i]) put_byte(d[i]);
    edge_cond(1'b0);
  endtask
  // read the length byte then n bytes, nack the last and stop
  task automatic read_regs(input logic [6:0] a, input logic [7:0] idx, input int n,
                           output logic [7:0] q [$]);
    logic [7:0] d;
    q = {};
    edge_cond(1'b1);
    put_byte({a, 1'b0});
    put_byte(idx);
    edge_cond(1'b1);
    put_byte({a, 1'b1});
    for (int i = 0; i <= n; i++) begin
      get_byte(i == n, d);
      q.push_back(d);
    end
    edge_cond(1'b0);
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
// self-checking bench for the id and read length registers
module testbench;
  localparam logic [6:0] addr = 7'h69; // arbitrary value
  localparam logic [3:0] rev = 4'h3; // arbitrary value
  localparam logic [3:0] maker = 4'h5; // arbitrary value
  localparam logic [7:0] part = 8'h5a; // arbitrary value
  logic clock, reset, clk_en, scl, sda_drv, sda_out_ff, sda_oe_n_ff;
  logic [4:0] read_len_ff;
  logic [7:0] q [$]; // bytes from the last read
  int fails, cmp_count, cyc;
  wire logic sda_line = sda_drv & sda_oe_n_ff; // pulled-up wire
  smbus_id_bytecount_regs #(.dev_addr(addr), .rev_code(rev), .maker_code(maker), .part_code(part))
    uut (.clock(clock), .reset(reset), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
    .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff), .read_len_ff(read_len_ff));
  smbus_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // byte compare
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare the last read against a list
  task automatic check_q(input logic [7:0] e [$]);
    cmp(8'(q.size()), 8'(e.size()));
    foreach (e[i]) cmp(q[i], e[i]);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // values after reset, with a short freeze first
  task automatic t_defaults;
    clk_en <= 1'b0;
    repeat (5) @(posedge clock);
    clk_en <= 1'b1;
    cmp({3'h0, read_len_ff}, 8'h08);
    cmp({7'h0, sda_out_ff}, 8'h00);
    host.read_regs(addr, 8'h04, 5, q);
    check_q('{8'h08, 8'h00, {rev, maker}, part, 8'h08, 8'h00});
    $display("defaults done");
  endtask
  // reset in mid-run brings the length back to its value after reset
  task automatic t_reset;
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    cmp({3'h0, read_len_ff}, 8'h08);
    host.read_regs(addr, 8'h07, 1, q);
    check_q('{8'h08, 8'h08});
    $display("reset done");
  endtask
  // all-ones over bytes 4..8, then the smallest count
  task automatic t_write;
    host.write_regs(addr, 8'h04, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    cmp({3'h0, read_len_ff}, 8'h1f);
    host.read_regs(addr, 8'h04, 5, q);
    check_q('{8'h1f, 8'h00, {rev, maker}, part, 8'h1f, 8'h00});
    host.write_regs(addr, 8'h07, '{8'h00});
    host.read_regs(addr, 8'h07, 1, q);
    check_q('{8'h00, 8'h00});
    $display("write done");
  endtask
  // foreign address leaves the line alone
  task automatic t_refuse;
    cmp({7'h0, host.nak_seen}, 8'h00);
    host.read_regs(7'h6a, 8'h05, 1, q);
    check_q('{8'hff, 8'hff});
    cmp({7'h0, host.nak_seen}, 8'h01);
    $display("refuse done");
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    t_defaults();
    t_write();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule
